// file: inc/pcg_pkg.sv
// Constants, field layout and mode type for the clock mode generator
package pcg_pkg;

    localparam int APB_AW = 16;
    localparam int APB_DW = 32;
    localparam logic [APB_AW-1:0] CTRL_ADDR = 16'h0058;

    localparam int MUL_HI = 15;
    localparam int MUL_LO = 12;
    localparam int DIV_BIT = 11;
    localparam int CNT_HI = 10;
    localparam int CNT_LO = 3;
    localparam int ON_BIT = 2;
    localparam int NDIV_BIT = 1;
    localparam int STAT_BIT = 0;

    localparam logic [3:0] MUL_UNITY = 4'hF;

    localparam logic [2:0] PINS_000 = 3'h0;
    localparam logic [2:0] PINS_001 = 3'h1;
    localparam logic [2:0] PINS_010 = 3'h2;
    localparam logic [2:0] PINS_011 = 3'h3;
    localparam logic [2:0] PINS_100 = 3'h4;
    localparam logic [2:0] PINS_101 = 3'h5;
    localparam logic [2:0] PINS_110 = 3'h6;
    localparam logic [2:0] PINS_111 = 3'h7;

    localparam logic [15:0] RST_000 = 16'h0000;
    localparam logic [15:0] RST_001 = 16'h9007;
    localparam logic [15:0] RST_010 = 16'h4007;
    localparam logic [15:0] RST_100 = 16'h1007;
    localparam logic [15:0] RST_110 = 16'hF007;
    localparam logic [15:0] RST_111 = 16'h0000;
    localparam logic [15:0] RST_101 = 16'hF000;
    localparam logic [15:0] RST_011 = 16'h0000;

    localparam int LOCK_SHIFT = 4;
    localparam int PER_W = 16;

    typedef enum {PCG_DIV, PCG_LOCKING, PCG_PLL} pcg_mode_e;

endpackage

// file: rtl/pcg_lock_timer.sv
// Lock timer counting reference edges before the loop counts as locked
`timescale 1ns/1ps
module pcg_lock_timer #(
    parameter int CNT_W = 8,
    parameter int SHIFT = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic tick,
    input wire logic [CNT_W-1:0] count,
    output logic locked
);
    logic [CNT_W+SHIFT-1:0] remain_q;
    logic running_q;

    // Load scaled count on start, count down on reference edges
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            remain_q <= '0;
            running_q <= 1'b0;
            locked <= 1'b0;
        end
        else if (start)
        begin
            remain_q <= (CNT_W+SHIFT)'(count) << SHIFT;
            running_q <= 1'b1;
            locked <= 1'b0;
        end
        else if (running_q)
        begin
            if (remain_q == '0)
            begin
                running_q <= 1'b0;
                locked <= 1'b1;
            end
            else if (tick)
            begin
                remain_q <= remain_q - 1'b1;
            end
        end
    end

endmodule

// file: rtl/pcg_clock_gen.sv
// Clock mode generator with divider, synthesised multiplier and APB register
`timescale 1ns/1ps
module pcg_clock_gen #(
    parameter int CNT_W = 8,
    parameter int SHIFT = pcg_pkg::LOCK_SHIFT,
    parameter int PER_W = pcg_pkg::PER_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcg_pkg::APB_AW-1:0] paddr,
    input wire logic [pcg_pkg::APB_DW-1:0] pwdata,
    output logic [pcg_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic referenceClockIn,
    input wire logic modeSelectPinA,
    input wire logic modeSelectPinB,
    input wire logic modeSelectPinC,
    output logic masterClk,
    output logic crystalDriveOut,
    output logic oscEnable,
    output logic pllEnable,
    output logic pllLocked
);
    localparam int ACC_W = PER_W + 2;

    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    logic [2:0] strap_q;
    logic rstHold_q;
    logic refMeta_q;
    logic refSync_q;
    logic refLast_q;
    logic refRise;
    logic [15:0] ctrl_q;
    logic wrEn;
    logic addrHit;
    logic accessEn;
    logic [15:0] strapVal;
    logic useReq;
    logic timerStart_q;
    logic lockDone;
    pcg_pkg::pcg_mode_e mode_q;
    logic divOut_q;
    logic divPhase_q;
    logic [PER_W-1:0] perCnt_q;
    logic [PER_W-1:0] refPeriod_q;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic ncoOut_q;
    logic ncoToggle;
    logic [4:0] mult;
    logic [5:0] inc;
    logic [ACC_W:0] sum;
    logic [ACC_W:0] thr;
    logic [15:0] nextCtrl;
    logic mstNext;
    logic mstMoved_q;

    // Pin synchronisers run without reset so the pins stay visible in reset
    always_ff @(posedge clk)
    begin
        pinMeta <= {modeSelectPinA, modeSelectPinB, modeSelectPinC};
        pinSync <= pinMeta;
    end

    // Reset window marker, cleared at the first edge after release
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstHold_q <= 1'b1;
        end
        else
        begin
            rstHold_q <= 1'b0;
        end
    end

    // Strap capture while reset is held
    always_ff @(posedge clk)
    begin
        if (rstHold_q)
        begin
            strap_q <= pinSync;
        end
    end

    // Oscillator enable tracks the pins, off only for 000
    always_ff @(posedge clk)
    begin
        oscEnable <= (pinSync != pcg_pkg::PINS_000);
    end

    // Strap decode to reset value
    always_comb
    begin
        unique case (strap_q)
            pcg_pkg::PINS_000: strapVal = pcg_pkg::RST_000;
            pcg_pkg::PINS_001: strapVal = pcg_pkg::RST_001;
            pcg_pkg::PINS_010: strapVal = pcg_pkg::RST_010;
            pcg_pkg::PINS_100: strapVal = pcg_pkg::RST_100;
            pcg_pkg::PINS_110: strapVal = pcg_pkg::RST_110;
            pcg_pkg::PINS_111: strapVal = pcg_pkg::RST_111;
            pcg_pkg::PINS_101: strapVal = pcg_pkg::RST_101;
            pcg_pkg::PINS_011: strapVal = pcg_pkg::RST_011;
            default: strapVal = pcg_pkg::RST_000;
        endcase
    end

    // Reference input synchroniser and edge detect
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            refMeta_q <= 1'b0;
            refSync_q <= 1'b0;
            refLast_q <= 1'b0;
        end
        else
        begin
            refMeta_q <= referenceClockIn;
            refSync_q <= refMeta_q;
            refLast_q <= refSync_q;
        end
    end

    assign refRise = refSync_q & ~refLast_q;

    // Crystal drive inverts the reference while the oscillator is on
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            crystalDriveOut <= 1'b0;
        end
        else
        begin
            crystalDriveOut <= oscEnable & ~refSync_q;
        end
    end

    // APB decode, one wait state per access
    assign addrHit = (paddr == pcg_pkg::CTRL_ADDR);
    assign accessEn = psel & penable & pready;
    assign wrEn = accessEn & pwrite & addrHit;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else if (psel & penable & ~pready)
        begin
            pready <= 1'b1;
            pslverr <= ~addrHit;
            if (!pwrite && addrHit)
            begin
                prdata <= {16'h0000, ctrl_q[15:1], mode_q == pcg_pkg::PCG_PLL};
            end
            else
            begin
                prdata <= '0;
            end
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Next register value from a write; status bit is read only
    assign nextCtrl = {pwdata[15:1], 1'b0};

    // Clock mode register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= '0;
        end
        else if (rstHold_q)
        begin
            ctrl_q <= strapVal;
        end
        else if (wrEn)
        begin
            ctrl_q <= nextCtrl;
        end
    end

    // Loop requested only when powered and selected
    assign useReq = ctrl_q[pcg_pkg::NDIV_BIT] & ctrl_q[pcg_pkg::ON_BIT];

    // Loop power follows its enable bit
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pllEnable <= 1'b0;
        end
        else
        begin
            pllEnable <= ctrl_q[pcg_pkg::ON_BIT];
        end
    end

    // Restart lock timing whenever a new setting asks for the loop
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timerStart_q <= 1'b0;
        end
        else
        begin
            timerStart_q <= rstHold_q | wrEn;
        end
    end

    pcg_lock_timer #(
        .CNT_W(CNT_W),
        .SHIFT(SHIFT)
    ) u_lock (
        .clk(clk),
        .arst_n(arst_n),
        .start(timerStart_q),
        .tick(refRise),
        .count(ctrl_q[pcg_pkg::CNT_HI:pcg_pkg::CNT_LO]),
        .locked(lockDone)
    );

    // Mode sequencing: divider, acquiring lock, loop clocking
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_q <= pcg_pkg::PCG_DIV;
        end
        else if (!useReq)
        begin
            mode_q <= pcg_pkg::PCG_DIV;
        end
        else if (timerStart_q)
        begin
            mode_q <= pcg_pkg::PCG_LOCKING;
        end
        else
        begin
            unique case (mode_q)
                pcg_pkg::PCG_DIV: mode_q <= pcg_pkg::PCG_LOCKING;
                pcg_pkg::PCG_LOCKING:
                begin
                    if (lockDone)
                    begin
                        mode_q <= pcg_pkg::PCG_PLL;
                    end
                end
                pcg_pkg::PCG_PLL: mode_q <= pcg_pkg::PCG_PLL;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pllLocked <= 1'b0;
        end
        else
        begin
            pllLocked <= useReq & lockDone;
        end
    end

    // Divider: toggle every reference edge, or every second for divide by four
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            divOut_q <= 1'b0;
            divPhase_q <= 1'b0;
        end
        else if (refRise)
        begin
            if (ctrl_q[pcg_pkg::MUL_HI:pcg_pkg::MUL_LO] == pcg_pkg::MUL_UNITY)
            begin
                divPhase_q <= ~divPhase_q;
                if (divPhase_q)
                begin
                    divOut_q <= ~divOut_q;
                end
            end
            else
            begin
                divPhase_q <= 1'b0;
                divOut_q <= ~divOut_q;
            end
        end
    end

    // Reference period measurement, refreshed each reference cycle for tracking
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            perCnt_q <= '0;
            refPeriod_q <= '0;
        end
        else if (!ctrl_q[pcg_pkg::ON_BIT])
        begin
            perCnt_q <= '0;
        end
        else if (refRise)
        begin
            refPeriod_q <= perCnt_q + 1'b1;
            perCnt_q <= '0;
        end
        else if (perCnt_q != '1)
        begin
            perCnt_q <= perCnt_q + 1'b1;
        end
    end

    // Ratio select: multiplier field plus one, all ones means unity unless the divide bit is set
    always_comb
    begin
        if (ctrl_q[pcg_pkg::MUL_HI:pcg_pkg::MUL_LO] == pcg_pkg::MUL_UNITY && !ctrl_q[pcg_pkg::DIV_BIT])
        begin
            mult = 5'h01;
        end
        else
        begin
            mult = 5'(ctrl_q[pcg_pkg::MUL_HI:pcg_pkg::MUL_LO]) + 5'h01;
        end
        inc = {mult, 1'b0};
        if (ctrl_q[pcg_pkg::DIV_BIT])
        begin
            thr = (ACC_W+1)'({refPeriod_q, 1'b0});
        end
        else
        begin
            thr = (ACC_W+1)'(refPeriod_q);
        end
        sum = {1'b0, acc_q} + (ACC_W+1)'(inc);
        ncoToggle = (refPeriod_q != '0) && (sum >= thr);
        if (ncoToggle)
        begin
            acc_d = ACC_W'(sum - thr);
        end
        else if (refPeriod_q == '0)
        begin
            acc_d = '0;
        end
        else
        begin
            acc_d = ACC_W'(sum);
        end
    end

    // Phase accumulator synthesising reference times the ratio
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_q <= '0;
            ncoOut_q <= 1'b0;
        end
        else if (!ctrl_q[pcg_pkg::ON_BIT])
        begin
            acc_q <= '0;
            ncoOut_q <= 1'b0;
        end
        else
        begin
            acc_q <= acc_d;
            if (ncoToggle)
            begin
                ncoOut_q <= ~ncoOut_q;
            end
        end
    end

    // Master clock source select
    assign mstNext = (mode_q == pcg_pkg::PCG_PLL) ? ncoOut_q : divOut_q;

    // Hold one cycle after each change so a source swap never makes a runt pulse
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            masterClk <= 1'b0;
            mstMoved_q <= 1'b0;
        end
        else if (mstMoved_q)
        begin
            mstMoved_q <= 1'b0;
        end
        else
        begin
            masterClk <= mstNext;
            mstMoved_q <= (mstNext != masterClk);
        end
    end

endmodule

// file: verif/pcg_clock_gen_sva.sv
// Port checker for the clock mode generator
`timescale 1ns/1ps
module pcg_clock_gen_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcg_pkg::APB_AW-1:0] paddr,
    input wire logic [pcg_pkg::APB_DW-1:0] pwdata,
    input wire logic [pcg_pkg::APB_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic referenceClockIn,
    input wire logic modeSelectPinA,
    input wire logic modeSelectPinB,
    input wire logic modeSelectPinC,
    input wire logic masterClk,
    input wire logic crystalDriveOut,
    input wire logic oscEnable,
    input wire logic pllEnable,
    input wire logic pllLocked
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    sequence accessStart;
        psel && penable && !$past(penable);
    endsequence
    sequence pinsSteady;
        $stable({modeSelectPinA, modeSelectPinB, modeSelectPinC})[*4];
    endsequence
    sequence ctrlWrite;
        pready && pwrite && !pslverr;
    endsequence
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    ready_timing_a: assert property (accessStart |=> pready && psel)
        else $error("pready late");
    slverr_addr_a: assert property (pready |-> pslverr == (paddr != pcg_pkg::CTRL_ADDR))
        else $error("pslverr wrong");
    rdata_width_a: assert property (pready |-> prdata[31:16] == 16'h0000 && (!pslverr || prdata == 32'h0))
        else $error("prdata wrong");
    master_rate_a: assert property ($changed(masterClk) |=> $stable(masterClk))
        else $error("master too fast");
    osc_follow_a: assert property (pinsSteady |-> oscEnable == |{modeSelectPinA, modeSelectPinB, modeSelectPinC})
        else $error("osc enable wrong");
    crystal_off_a: assert property (!oscEnable [*2] |-> !crystalDriveOut)
        else $error("crystal driven");
    loop_down_a: assert property (!pllEnable [*3] |-> !pllLocked)
        else $error("locked unpowered");
    lock_restart_a: assert property (ctrlWrite ##0 (!pwdata[2] || pwdata[10:5] != 6'h00) |-> ##[1:3] !pllLocked)
        else $error("lock kept");
endmodule
bind pcg_clock_gen pcg_clock_gen_sva u_pcg_clock_gen_sva (.*);

// file: verif/pcg_ref_model.sv
// Board model: free running reference source and strap pins
`timescale 1ns/1ps
module pcg_ref_model #(
    parameter int HALF_NS = 200
) (
    input wire logic [2:0] strapReq,
    output logic refClk,
    output logic pinA,
    output logic pinB,
    output logic pinC
);
    initial refClk = 1'b0;
    always #HALF_NS refClk = ~refClk;
    // Reserved code never reaches the pins
    assign {pinA, pinB, pinC} = (strapReq == 3'h3) ? 3'h7 : strapReq;
endmodule

// file: verif/pcg_clock_gen_tb_top.sv
// Self-checking testbench for the clock mode generator
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin fails++; $display("unexpected %0t %h %h", $time, g, e); end end
module pcg_clock_gen_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic referenceClockIn;
    logic modeSelectPinA;
    logic modeSelectPinB;
    logic modeSelectPinC;
    logic masterClk;
    logic crystalDriveOut;
    logic oscEnable;
    logic pllEnable;
    logic pllLocked;
    logic [2:0] strap = 3'h0;
    logic [31:0] rd;
    logic err;
    logic [15:0] w;
    logic [15:0] a;
    int fails = 0;
    int nTests = 0;
    int cycles = 0;
    int refCnt = 0;
    int mstCnt = 0;
    logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h5};
    logic [15:0] vals [7] = '{16'h0000, 16'h9007, 16'h4007, 16'h1007, 16'hF007, 16'h0000, 16'hF000};
    logic [15:0] modes [6] = '{16'h0000, 16'hF000, 16'hF006, 16'h9006, 16'h3806, 16'h0002};
    always #5 clk = ~clk;
    always @(posedge referenceClockIn) refCnt++;
    always @(posedge masterClk) mstCnt++;
    pcg_ref_model u_pcg_ref_model (
        .strapReq(strap),
        .refClk(referenceClockIn),
        .pinA(modeSelectPinA),
        .pinB(modeSelectPinB),
        .pinC(modeSelectPinC)
    );
    pcg_clock_gen #(.SHIFT(0)) u_pcg_clock_gen (.*);
    function automatic int expEdges(input logic [15:0] v, input int n);
        if (!(v[2] && v[1]))
            return (v[15:12] == 4'hF) ? n / 4 : n / 2;
        if (v[15:12] == 4'hF && !v[11])
            return n;
        return v[11] ? n * (v[15:12] + 1) / 2 : n * (v[15:12] + 1);
    endfunction
    task automatic apb(input logic wr, input logic [15:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic measure(input logic [15:0] v);
        int r0;
        int m0;
        int e;
        apb(1'b1, 16'h0058, {16'h0000, v});
        repeat (600) @(posedge clk);
        r0 = refCnt;
        m0 = mstCnt;
        repeat (2000) @(posedge clk);
        e = expEdges(v, refCnt - r0);
        `CHK((mstCnt - m0 >= e - 2) && (mstCnt - m0 <= e + 2), 1'b1)
        `CHK(pllEnable, v[2])
        `CHK(pllLocked, v[2] & v[1])
        apb(1'b0, 16'h0058, 32'h0);
        `CHK(rd[15:0], {v[15:1], v[2] & v[1]})
        $display("done mode %h", v);
    endtask
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fails++;
            reportAndStop();
        end
    end
    initial
    begin
        void'($urandom(35289));
        repeat (5) @(posedge clk);
        for (int i = 0; i < 7; i++)
        begin
            arst_n <= 1'b0;
            strap <= codes[i];
            repeat (6) @(posedge clk);
            arst_n <= 1'b1;
            repeat (300) @(posedge clk);
            apb(1'b0, 16'h0058, 32'h0);
            `CHK(rd, {16'h0000, vals[i]})
            `CHK(oscEnable, codes[i] != 3'h0)
            if (codes[i] == 3'h0)
                `CHK(crystalDriveOut, 1'b0)
            strap <= codes[6 - i];
            repeat (8) @(posedge clk);
            `CHK(oscEnable, codes[6 - i] != 3'h0)
            apb(1'b0, 16'h0058, 32'h0);
            `CHK(rd, {16'h0000, vals[i]})
            $display("done strap %h", codes[i]);
            @(posedge clk);
        end
        for (int i = 0; i < 6; i++)
        begin
            w = 16'($urandom);
            w[10:5] = 6'h01;
            a = 16'($urandom) & 16'hFFFC;
            if (a == 16'h0058)
                a = 16'h005C;
            apb(1'b1, 16'h0058, {16'($urandom), w});
            apb(1'b0, 16'h0058, 32'h0);
            `CHK(rd[0], 1'b0)
            apb(1'b1, a, 32'hFFFF_FFFF);
            `CHK(err, 1'b1)
            apb(1'b0, a, 32'h0);
            `CHK({err, rd}, {1'b1, 32'h0})
            repeat (400) @(posedge clk);
            apb(1'b0, 16'h0058, 32'h0);
            `CHK(rd, {16'h0000, w[15:1], w[2] & w[1]})
            $display("done write %h", w);
        end
        for (int i = 0; i < 8; i++)
            measure(i < 6 ? modes[i] : {4'($urandom_range(9)), 1'($urandom), 11'h006});
        reportAndStop();
    end
endmodule
